// ### dv/spq_link_model.sv
// Serial slave that echoes each byte one transfer later
`timescale 1ns/1ps
module spq_link_model
(
	// Link pins
	input wire i_sck,
	input wire i_mosi,
	output wire o_miso,
	// Observation
	output logic [7:0] o_sr,
	output int o_bits
);
	logic cap;
	// The first falling level after power-up is not a real edge: shift only after a rise
	logic armed = 1'b0;
	initial o_sr = 8'hA5;
	initial o_bits = 0;
	// Output moves only on falling edges so it is stable at the sampling edge
	assign o_miso = o_sr[7];
	always @(posedge i_sck)
	begin
		cap <= i_mosi;
		armed <= 1'b1;
		o_bits <= o_bits + 1;
	end
	always @(negedge i_sck)
	begin
		if (armed)
			o_sr <= {o_sr[6:0], cap};
	end
endmodule // spq_link_model

// ### dv/spq_port_properties.sv
// Concurrent checks on the serial port's bus and pin ports
`timescale 1ns/1ps
module spq_port_properties
(
	// Watched ports
	input wire i_clk,
	input wire i_sys_rst,
	input wire [3:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [31:0] o_readdata,
	input wire o_waitrequest,
	input wire o_irq,
	input wire o_serial_out_oe_n,
	input wire o_shift_clock_oe_n,
	input wire o_select_n_oe_n
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////
	sequence wr_ack(a);
		i_write && !o_waitrequest && i_address == a;
	endsequence
	sequence rd_ack;
		i_read && !o_waitrequest;
	endsequence
	////////////////////////////////////////
	wait_first_a: assert property ($rose(i_read || i_write) |-> o_waitrequest)
		else $error("new request got no wait state");
	wait_once_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("request not answered after one wait");
	upper_zero_a: assert property (rd_ack |-> o_readdata[31:16] == 16'h0000)
		else $error("upper read lanes not zero");
	unmapped_zero_a: assert property (rd_ack ##0 i_address > 4'h5 |-> o_readdata == 32'h0)
		else $error("unmapped read not zero");
	mask_quiet_a: assert property (wr_ack(4'h5) ##0 i_writedata[3:0] == 4'h0 |=> !o_irq)
		else $error("irq high with all masked");
	two_pin_a: assert property (wr_ack(4'h1) ##0 i_writedata[8] |=> o_serial_out_oe_n && o_select_n_oe_n)
		else $error("two-pin mode drives data-out or select");
	three_pin_a: assert property (wr_ack(4'h1) ##0 i_writedata[9] |=> o_select_n_oe_n)
		else $error("three-pin mode drives select");
	port_off_a: assert property (wr_ack(4'h0) ##0 !i_writedata[15] |=> (o_shift_clock_oe_n && o_serial_out_oe_n)[*2])
		else $error("disabled port drives pins");
	reset_quiet_a: assert property (disable iff (1'b0) i_sys_rst |-> o_shift_clock_oe_n && o_serial_out_oe_n)
		else $error("pins driven in reset");
endmodule // spq_port_properties
bind spq_port spq_port_properties u_props (.*);

// ### dv/spq_port_tb_top.sv
// Self-checking bench for the queued serial port
`timescale 1ns/1ps
`include "spq_defs.vh"
module spq_port_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b0;
	logic idle = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic [31:0] seed = 32'h4C52;
	logic [7:0] b [0:9];
	logic [7:0] sr;
	wire wt, irq, mosi, miso, sck, ssn;
	int bits;
	int mismatches = 0;
	int checks = 0;
	always #2 clk = ~clk;
	spq_port DUT (.i_clk(clk), .i_sys_rst(rst), .i_cpu_idle(idle), .i_address(adr), .i_read(rd),
		.i_write(wr), .i_writedata(wd), .i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(wt),
		.o_irq(irq), .i_serial_in(miso), .o_serial_out(mosi), .o_serial_out_oe_n(), .i_shift_clock(sck),
		.o_shift_clock(sck), .o_shift_clock_oe_n(), .i_select_n(1'b1), .o_select_n(ssn), .o_select_n_oe_n());
	spq_link_model u_peer (.i_sck(sck), .i_mosi(mosi), .o_miso(miso), .o_sr(sr), .o_bits(bits));
	////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Request held until the edge that samples waitrequest low
	task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d);
		@(posedge clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {16'h0000, d};
		@(posedge clk);
		while (wt !== 1'b0)
			@(posedge clk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		bus(a, 1'b0, 16'h0000);
		chk(q, e);
	endtask
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#20000;
		mismatches++;
		finish_test;
	end
	////////////////////////////////////////
	initial
	begin
		// Raised at time zero by an update, so the design sees a real reset edge
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdc(`SPQ_ADDR_CON1, 32'h20);
		rdc(`SPQ_ADDR_STAT, 32'h0);
		rdc(4'h9, 32'h0);
		bus(`SPQ_ADDR_CON1, 1'b1, 16'h0023);
		bus(`SPQ_ADDR_CON2, 1'b1, 16'h0001);
		bus(`SPQ_ADDR_IMASK, 1'b1, 16'h0002);
		bus(`SPQ_ADDR_STAT, 1'b1, 16'h8000);
		// Ten writes: one shifting, eight queued, the last refused
		for (int i = 0; i < 10; i++)
		begin
			seed = xs(seed);
			b[i] = seed[7:0];
			bus(`SPQ_ADDR_BUF, 1'b1, {8'h00, b[i]});
		end
		rdc(`SPQ_ADDR_STAT, 32'h8002);
		while (bits < 72)
			@(posedge clk);
		repeat (12) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rdc(`SPQ_ADDR_STAT, 32'h8041);
		for (int i = 0; i < 8; i++)
			rdc(`SPQ_ADDR_BUF, (i == 0) ? 32'hA5 : {24'h0, b[i - 1]});
		rdc(`SPQ_ADDR_STAT, 32'h8040);
		chk({24'h0, sr}, {24'h0, b[8]});
		rdc(`SPQ_ADDR_IFLAG, 32'hF);
		bus(`SPQ_ADDR_IFLAG, 1'b1, 16'h000F);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdc(`SPQ_ADDR_IFLAG, 32'h0);
		bus(`SPQ_ADDR_STAT, 1'b1, 16'h8000);
		bus(`SPQ_ADDR_CON2, 1'b1, 16'h0000);
		bus(`SPQ_ADDR_BUF, 1'b1, {8'h00, b[9]});
		repeat (2) @(posedge clk);
		chk({31'h0, ssn}, 32'h0);
		while (bits < 80)
			@(posedge clk);
		repeat (12) @(posedge clk);
		rdc(`SPQ_ADDR_BUF, {24'h0, b[8]});
		chk({24'h0, sr}, {24'h0, b[9]});
		chk({31'h0, ssn}, 32'h1);
		// Idle-stop set and processor idle: the buffer write is refused, nothing shifts
		idle <= 1'b1;
		bus(`SPQ_ADDR_STAT, 1'b1, 16'hA000);
		bus(`SPQ_ADDR_BUF, 1'b1, 16'h005A);
		repeat (40) @(posedge clk);
		chk(bits, 32'd80);
		rdc(`SPQ_ADDR_STAT, 32'hA000);
		idle <= 1'b0;
		bus(`SPQ_ADDR_IMASK, 1'b1, 16'h0000);
		bus(`SPQ_ADDR_CON1, 1'b1, 16'h0223);
		bus(`SPQ_ADDR_CON1, 1'b1, 16'h0123);
		bus(`SPQ_ADDR_STAT, 1'b1, 16'h0000);
		repeat (4) @(posedge clk);
		finish_test;
	end
endmodule // spq_port_tb_top

// ### hdl/spq_defs.vh
// Register map, field positions, reset values and queue sizes for the serial port
`ifndef SPQ_DEFS_VH
`define SPQ_DEFS_VH

// Word addresses on the register bus (byte address = 4 * index)
`define SPQ_ADDR_STAT 4'h0
`define SPQ_ADDR_CON1 4'h1
`define SPQ_ADDR_CON2 4'h2
`define SPQ_ADDR_BUF 4'h3
`define SPQ_ADDR_IFLAG 4'h4
`define SPQ_ADDR_IMASK 4'h5

// status_control_reg fields
`define SPQ_STAT_EN 15
`define SPQ_STAT_SIDL 13
`define SPQ_STAT_ROV 6
`define SPQ_STAT_TBF 1
`define SPQ_STAT_RBF 0

// control_reg_one fields
`define SPQ_CON1_PRE_LO 0
`define SPQ_CON1_PRE_HI 4
`define SPQ_CON1_CKP 6
`define SPQ_CON1_MSTEN 5
`define SPQ_CON1_MODE16 10
`define SPQ_CON1_DISSDO 11
`define SPQ_CON1_DISSCK 12
`define SPQ_CON1_PIN2 8
`define SPQ_CON1_PIN3 9

// control_reg_two fields
`define SPQ_CON2_FRMEN 15
`define SPQ_CON2_FSYNC_IN 14
`define SPQ_CON2_FSYNC_POL 13
`define SPQ_CON2_FSYNC_EDGE 1
`define SPQ_CON2_ENHBUF 0

// Interrupt event bits
`define SPQ_EV_DONE 0
`define SPQ_EV_ROV 1
`define SPQ_EV_RXAV 2
`define SPQ_EV_TXEMPTY 3

`define SPQ_CON1_RST 16'h0020
`define SPQ_CON2_RST 16'h0000
`define SPQ_DEPTH 8
`define SPQ_PTR_W 3
`define SPQ_CNT_W 4
`endif

// ### hdl/spq_port.v
// Serial port with shared buffer address, standard or eight-deep queued buffering
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "spq_defs.vh"

module spq_port
(
	// Clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// Processor idle request
	input wire i_cpu_idle,
	// Avalon-MM slave
	input wire [3:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [3:0] i_byteenable,
	output wire [31:0] o_readdata,
	output wire o_waitrequest,
	// Interrupt
	output wire o_irq,
	// Serial link
	input wire i_serial_in,
	output wire o_serial_out,
	output wire o_serial_out_oe_n,
	input wire i_shift_clock,
	output wire o_shift_clock,
	output wire o_shift_clock_oe_n,
	input wire i_select_n,
	output wire o_select_n,
	output wire o_select_n_oe_n
);

	////////////////////////////////////////////////////////////////////////////
	// Registers
	reg en_r;
	reg sidl_r;
	reg rov_r;
	reg [15:0] con1_r;
	reg [15:0] con2_r;
	reg [3:0] iflag_r;
	reg [3:0] imask_r;
	reg [31:0] rdata_r;
	reg ack_r;

	wire mst = con1_r[`SPQ_CON1_MSTEN];
	wire mode16 = con1_r[`SPQ_CON1_MODE16];
	wire ckp = con1_r[`SPQ_CON1_CKP];
	wire pin2 = con1_r[`SPQ_CON1_PIN2];
	wire pin3 = con1_r[`SPQ_CON1_PIN3];
	wire [4:0] pre = con1_r[`SPQ_CON1_PRE_HI:`SPQ_CON1_PRE_LO];
	wire frmen = con2_r[`SPQ_CON2_FRMEN];
	wire fs_in = con2_r[`SPQ_CON2_FSYNC_IN];
	wire fs_pol = con2_r[`SPQ_CON2_FSYNC_POL];
	wire fs_edge = con2_r[`SPQ_CON2_FSYNC_EDGE];
	// Queueing off means one-deep holding registers, suited to DMA service
	wire enh = con2_r[`SPQ_CON2_ENHBUF];
	wire run_en = en_r & ~(sidl_r & i_cpu_idle);

	// One-wait answer: waitrequest is high only in the first request cycle
	wire req = i_read | i_write;
	assign o_waitrequest = req & ~ack_r;
	wire acc = req & ack_r;
	wire wr = acc & i_write;
	wire rd = acc & i_read;
	wire buf_wr = wr & (i_address == `SPQ_ADDR_BUF) & i_byteenable[0];
	wire buf_rd = rd & (i_address == `SPQ_ADDR_BUF);

	////////////////////////////////////////////////////////////////////////////
	// Queues: depth 8 in enhanced mode, 1 in standard mode
	reg [15:0] txq [0:`SPQ_DEPTH-1];
	reg [15:0] rxq [0:`SPQ_DEPTH-1];
	// Pointers wrap at eight; standard mode pins them to entry 0, the holding register
	reg [2:0] tx_wp_r;
	reg [2:0] tx_rp_r;
	reg [2:0] rx_wp_r;
	reg [2:0] rx_rp_r;
	reg [3:0] tx_cnt_r;
	reg [3:0] rx_cnt_r;
	wire [3:0] cap = enh ? 4'h8 : 4'h1;
	wire tx_full = (tx_cnt_r >= cap);
	wire rx_avail = (rx_cnt_r != 4'h0);
	wire rx_full = (rx_cnt_r >= cap);
	wire tx_push = buf_wr & ~tx_full & run_en;
	wire rx_pop = buf_rd & rx_avail;
	wire xfer_done;
	wire tx_pop;
	wire [15:0] sr_in_word;
	wire rx_push = xfer_done & ~rx_full;

	// One process per entry keeps every storage word single-driven
	genvar gi;
	generate
		for (gi = 0; gi < `SPQ_DEPTH; gi = gi + 1)
		begin : g_q
			always @(posedge i_clk or posedge i_sys_rst)
			begin
				if (i_sys_rst)
				begin
					txq[gi] <= 16'h0000;
					rxq[gi] <= 16'h0000;
				end
				else
				begin
					if (tx_push && tx_wp_r == gi)
						txq[gi] <= i_writedata[15:0];
					if (rx_push && rx_wp_r == gi)
						rxq[gi] <= sr_in_word;
				end
			end
		end
	endgenerate

	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			tx_wp_r <= 3'h0;
			tx_rp_r <= 3'h0;
			rx_wp_r <= 3'h0;
			rx_rp_r <= 3'h0;
			tx_cnt_r <= 4'h0;
			rx_cnt_r <= 4'h0;
		end
		else if (!en_r)
		begin
			// Disabling the port flushes both directions
			tx_wp_r <= 3'h0;
			tx_rp_r <= 3'h0;
			rx_wp_r <= 3'h0;
			rx_rp_r <= 3'h0;
			tx_cnt_r <= 4'h0;
			rx_cnt_r <= 4'h0;
		end
		else
		begin
			if (tx_push)
				tx_wp_r <= enh ? tx_wp_r + 3'h1 : 3'h0;
			if (tx_pop)
				tx_rp_r <= enh ? tx_rp_r + 3'h1 : 3'h0;
			if (rx_push)
				rx_wp_r <= enh ? rx_wp_r + 3'h1 : 3'h0;
			if (rx_pop)
				rx_rp_r <= enh ? rx_rp_r + 3'h1 : 3'h0;
			tx_cnt_r <= tx_cnt_r + {3'h0, tx_push} - {3'h0, tx_pop};
			rx_cnt_r <= rx_cnt_r + {3'h0, rx_push} - {3'h0, rx_pop};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shift engine
	localparam ST_IDLE = 3'h1;
	localparam ST_SHIFT = 3'h2;
	localparam ST_DONE = 3'h4;
	reg [2:0] st_r;
	reg [15:0] sr_r;
	reg [4:0] bit_r;
	reg [4:0] div_r;
	reg sck_r;
	reg sck_in_d_r;
	reg sel_d_r;
	reg fpulse_r;
	wire [4:0] nbits = mode16 ? 5'h10 : 5'h08;
	assign sr_in_word = mode16 ? sr_r : {8'h00, sr_r[7:0]};
	wire [15:0] tx_word = txq[tx_rp_r];

	// Master shift clock from a prescaled enable; slave follows the pin
	wire tick = (div_r == pre);
	wire sck_lvl = mst ? sck_r : (i_shift_clock ^ ckp);
	wire m_rise = mst & tick & ~sck_r;
	wire m_fall = mst & tick & sck_r;
	wire s_rise = ~mst & sck_lvl & ~(sck_in_d_r ^ ckp);
	wire s_fall = ~mst & ~sck_lvl & (sck_in_d_r ^ ckp);
	wire samp = m_rise | s_rise;
	wire shft = m_fall | s_fall;
	// Slave select only counts in four-pin mode
	wire sel_ok = (pin2 | pin3) ? 1'b1 : ~i_select_n;
	wire fs_in_lvl = i_select_n ^ ~fs_pol;
	wire fs_start = frmen & fs_in & (fs_edge ? (fs_in_lvl & ~sel_d_r) : fs_in_lvl);
	wire start_ok = mst ? (~frmen | ~fs_in | fs_start) : (frmen ? fs_start : sel_ok);
	reg sampled_bit_r;

	// One pop per frame, taken only from idle
	assign tx_pop = (st_r == ST_IDLE) & (tx_cnt_r != 4'h0) & run_en & start_ok;
	assign xfer_done = (st_r == ST_DONE);

	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st_r <= ST_IDLE;
			sr_r <= 16'h0000;
			bit_r <= 5'h00;
			div_r <= 5'h00;
			sck_r <= 1'b0;
			sck_in_d_r <= 1'b0;
			sel_d_r <= 1'b0;
			fpulse_r <= 1'b0;
			sampled_bit_r <= 1'b0;
		end
		else
		begin
			sck_in_d_r <= i_shift_clock;
			sel_d_r <= fs_in_lvl;
			// Divider rests at zero, so every frame opens with a full half period
			div_r <= (tick || st_r != ST_SHIFT) ? 5'h00 : div_r + 5'h01;
			case (st_r)
				ST_IDLE:
				begin
					sck_r <= 1'b0;
					fpulse_r <= 1'b0;
					if (tx_pop)
					begin
						sr_r <= mode16 ? tx_word : {tx_word[7:0], 8'h00};
						bit_r <= 5'h00;
						fpulse_r <= frmen & ~fs_in;
						st_r <= ST_SHIFT;
					end
				end
				ST_SHIFT:
				begin
					if (m_rise || m_fall)
						sck_r <= ~sck_r;
					if (m_rise)
						fpulse_r <= 1'b0;
					if (samp)
						sampled_bit_r <= i_serial_in;
					if (shft)
					begin
						sr_r <= {sr_r[14:0], sampled_bit_r};
						bit_r <= bit_r + 5'h01;
						if (bit_r == nbits - 5'h01)
							st_r <= ST_DONE;
					end
					if (!run_en || (!mst && !frmen && !sel_ok))
						st_r <= ST_IDLE;
				end
				ST_DONE:
				begin
					if (!mode16)
						sr_r <= {8'h00, sr_r[15:8]} | {8'h00, sr_r[7:0]};
					st_r <= ST_IDLE;
				end
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	// Pins: enables are active low; two-pin mode frees data-out and select
	// Byte mode loads the byte into the top half, so bit 15 leads either way
	wire top_bit = sr_r[15];
	assign o_serial_out = top_bit;
	assign o_serial_out_oe_n = ~(en_r & ~pin2 & ~con1_r[`SPQ_CON1_DISSDO]);
	assign o_shift_clock = sck_r ^ ckp;
	assign o_shift_clock_oe_n = ~(en_r & mst & ~con1_r[`SPQ_CON1_DISSCK]);
	assign o_select_n = fpulse_r ? ~fs_pol : (mst && !frmen) ? (st_r == ST_IDLE) : fs_pol;
	assign o_select_n_oe_n = ~(en_r & mst & ~pin2 & ~pin3 & (~frmen | ~fs_in));

	////////////////////////////////////////////////////////////////////////////
	// Control, status and interrupt registers
	wire [3:0] ev;
	assign ev[`SPQ_EV_DONE] = xfer_done;
	assign ev[`SPQ_EV_ROV] = xfer_done & rx_full;
	assign ev[`SPQ_EV_RXAV] = rx_push;
	assign ev[`SPQ_EV_TXEMPTY] = tx_pop & (tx_cnt_r == 4'h1);

	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			en_r <= 1'b0;
			sidl_r <= 1'b0;
			rov_r <= 1'b0;
			con1_r <= `SPQ_CON1_RST;
			con2_r <= `SPQ_CON2_RST;
			iflag_r <= 4'h0;
			imask_r <= 4'h0;
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= req & ~ack_r;
			if (wr && i_address == `SPQ_ADDR_STAT && i_byteenable[1])
			begin
				en_r <= i_writedata[`SPQ_STAT_EN];
				sidl_r <= i_writedata[`SPQ_STAT_SIDL];
			end
			// Hardware set wins over a software clear in the same cycle
			if (xfer_done && rx_full)
				rov_r <= 1'b1;
			else if (wr && i_address == `SPQ_ADDR_STAT && i_byteenable[0] && !i_writedata[`SPQ_STAT_ROV])
				rov_r <= 1'b0;
			if (wr && i_address == `SPQ_ADDR_CON1)
			begin
				if (i_byteenable[0])
					con1_r[7:0] <= i_writedata[7:0];
				if (i_byteenable[1])
					con1_r[15:8] <= i_writedata[15:8];
			end
			if (wr && i_address == `SPQ_ADDR_CON2)
			begin
				if (i_byteenable[0])
					con2_r[7:0] <= i_writedata[7:0];
				if (i_byteenable[1])
					con2_r[15:8] <= i_writedata[15:8];
			end
			if (wr && i_address == `SPQ_ADDR_IMASK && i_byteenable[0])
				imask_r <= i_writedata[3:0];
			if (wr && i_address == `SPQ_ADDR_IFLAG && i_byteenable[0])
				iflag_r <= (iflag_r & ~i_writedata[3:0]) | ev;
			else
				iflag_r <= iflag_r | ev;
		end
	end

	reg [15:0] stat_word;
	always @*
	begin
		stat_word = 16'h0000;
		stat_word[`SPQ_STAT_EN] = en_r;
		stat_word[`SPQ_STAT_SIDL] = sidl_r;
		stat_word[`SPQ_STAT_ROV] = rov_r;
		stat_word[`SPQ_STAT_TBF] = tx_full;
		stat_word[`SPQ_STAT_RBF] = rx_avail;
	end

	wire [15:0] rx_word = rxq[rx_rp_r];
	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h00000000;
		case (i_address)
			`SPQ_ADDR_STAT: rd_mux = {16'h0000, stat_word};
			`SPQ_ADDR_CON1: rd_mux = {16'h0000, con1_r};
			`SPQ_ADDR_CON2: rd_mux = {16'h0000, con2_r};
			`SPQ_ADDR_BUF: rd_mux = {16'h0000, rx_word};
			`SPQ_ADDR_IFLAG: rd_mux = {28'h0000000, iflag_r};
			`SPQ_ADDR_IMASK: rd_mux = {28'h0000000, imask_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Captured in the wait cycle so the word stands at the accepting edge
	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			rdata_r <= 32'h00000000;
		else if (i_read && !ack_r)
			rdata_r <= rd_mux;
	end

	assign o_readdata = rdata_r;
	assign o_irq = |(iflag_r & imask_r);

endmodule // spq_port
